// File: smb_pkg.sv
`default_nettype none
package smb_pkg;
  // bus address, upper seven bits of the address byte
  localparam logic [6:0] SLV_ADDR = 7'h69;
  // register indices
  localparam logic [6:0] REG_CTRL0 = 7'h00;
  localparam logic [6:0] REG_OEA = 7'h01;
  localparam logic [6:0] REG_OEB = 7'h02;
  localparam logic [6:0] REG_BCNT = 7'h04;
  localparam int unsigned NUM_CTRL = 3;
  // power-up values, index 0 in the low byte
  localparam logic [2:0][7:0] RST_CTRL = {8'hc0, 8'h05, 8'h00};
  localparam logic [7:0] RST_BCNT = 8'h07;
  // enable bit positions inside the two enable registers
  localparam int unsigned OE0_BIT = 2;
  localparam int unsigned OE1_BIT = 0;
  localparam int unsigned OE2_BIT = 7;
  localparam int unsigned OE3_BIT = 6;
  // command code: form bit, 1 = single byte, 0 = block
  localparam int unsigned CMD_FORM_BIT = 7;
  // bit positions within a frame, counted on scl rises
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
  // value sent once the block read limit is used up
  localparam logic [7:0] IDLE_BYTE = 8'hff;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_CMD   = 3'b010,
    ST_WCNT  = 3'b011,
    ST_WDATA = 3'b100,
    ST_RCNT  = 3'b101,
    ST_RDATA = 3'b110
  } smb_state_t;
endpackage
`default_nettype wire

// File: smb_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smb_link_if;
  logic scl;
  logic sda;
  logic rst_n;
  logic [7:0] shreg;
  modport cap (input scl, input sda, input rst_n, output shreg);
  modport core (output scl, output sda, output rst_n, input shreg);
endinterface
`default_nettype wire

// File: smb_link_cap.sv
`timescale 1ns/1ps
`default_nettype none
module smb_link_cap (
  smb_link_if.cap lnk
);
  // sda is stable while scl is high, so the scl rise is the sample point
  always_ff @(posedge lnk.scl or negedge lnk.rst_n) begin
    if (!lnk.rst_n) begin
      lnk.shreg <= 8'h00;
    end else begin
      lnk.shreg <= {lnk.shreg[6:0], lnk.sda};
    end
  end
endmodule
`default_nettype wire

// File: smb_cfg_slave.sv
`timescale 1ns/1ps
`default_nettype none
module smb_cfg_slave #(
  parameter logic [6:0] DEV_ADDR = smb_pkg::SLV_ADDR
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic REF_OUT0_ENABLE_O,
  output logic REF_OUT1_ENABLE_O,
  output logic REF_OUT2_ENABLE_O,
  output logic REF_OUT3_ENABLE_O
);
  import smb_pkg::*;

  smb_link_if lnk ();
  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic byte_end, ack_end, rd, addr_hit, wr_en, send_ok;
  smb_state_t st, next_st;
  logic [3:0] bitn;
  logic [6:0] idx;
  logic [7:0] rem, tx, rx, rd_byte, bcnt;
  logic blk, tx_on, acking;
  logic [7:0] regs [0:NUM_CTRL-1];

  // scl-domain byte capture, read here only while scl is low
  assign lnk.scl = SCL_I;
  assign lnk.sda = SDA_I;
  assign lnk.rst_n = RSTN_I;
  smb_link_cap u_cap (
    .lnk(lnk.cap)
  );
  assign rx = lnk.shreg;

  // two-flop synchronisers plus a history flop for edges
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_m <= SCL_I;
      scl_s <= scl_m;
      scl_q <= scl_s;
      sda_m <= SDA_I;
      sda_s <= sda_m;
      sda_q <= sda_s;
    end
  end

  // bus events; start and stop need scl high on both samples
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_ev = scl_s & scl_q & ~sda_q & sda_s;

  // frame decode, valid on the falls after bit 8 and the ack slot
  assign byte_end = scl_fall && (bitn == BYTE_BITS) && (st != ST_IDLE);
  assign ack_end = scl_fall && (bitn == ACK_SLOT);
  assign rd = (st == ST_RCNT) || (st == ST_RDATA);
  assign addr_hit = (rx[7:1] == DEV_ADDR);
  assign send_ok = !blk || (rem != 8'h00);
  assign wr_en = byte_end && (st == ST_WDATA) && send_ok;

  // read mux; unmapped indices read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (idx == REG_CTRL0 || idx == REG_OEA || idx == REG_OEB) begin
      rd_byte = regs[idx[1:0]];
    end else if (idx == REG_BCNT) begin
      rd_byte = bcnt;
    end
  end

  // transaction sequencing
  always_comb begin
    next_st = st;
    if (stop_ev) begin
      next_st = ST_IDLE;
    end else if (start_ev) begin
      next_st = ST_ADDR;
    end else if (byte_end) begin
      unique case (st)
        ST_ADDR: begin
          if (!addr_hit) begin
            next_st = ST_IDLE;
          end else if (!rx[0]) begin
            next_st = ST_CMD;
          end else begin
            next_st = blk ? ST_RCNT : ST_RDATA;
          end
        end
        ST_CMD: next_st = rx[CMD_FORM_BIT] ? ST_WDATA : ST_WCNT;
        ST_WCNT: next_st = ST_WDATA;
        ST_RCNT: next_st = ST_RDATA;
        default: next_st = st;
      endcase
    end else if (scl_rise && bitn == BYTE_BITS && rd && !acking && sda_s) begin
      next_st = ST_IDLE;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // bit position, counted on scl rises so the start's own fall is skipped
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      bitn <= 4'h0;
    end else if (start_ev || stop_ev || ack_end) begin
      bitn <= 4'h0;
    end else if (scl_rise && bitn != ACK_SLOT) begin
      bitn <= bitn + 4'h1;
    end
  end

  // form, index and remaining count; block always starts at index zero
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      blk <= 1'b0;
      idx <= 7'h00;
      rem <= 8'h00;
    end else if (byte_end && st == ST_CMD) begin
      blk <= ~rx[CMD_FORM_BIT];
      idx <= rx[CMD_FORM_BIT] ? rx[6:0] : 7'h00;
    end else if (byte_end && st == ST_WCNT) begin
      rem <= rx;
    end else if (wr_en) begin
      idx <= idx + 7'h01;
      if (blk) begin
        rem <= rem - 8'h01;
      end
    end else if (ack_end && st == ST_RCNT) begin
      rem <= bcnt;
    end else if (ack_end && st == ST_RDATA) begin
      idx <= idx + 7'h01;
      if (rem != 8'h00) begin
        rem <= rem - 8'h01;
      end
    end
  end

  // ack drive; no ack in idle or for a foreign address
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      acking <= 1'b0;
    end else if (start_ev || stop_ev || ack_end) begin
      acking <= 1'b0;
    end else if (byte_end) begin
      acking <= !rd && (st != ST_ADDR || addr_hit);
    end
  end

  // transmit shifter; bytes past the block limit read as all ones
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx <= IDLE_BYTE;
      tx_on <= 1'b0;
    end else if (start_ev || stop_ev || byte_end) begin
      tx_on <= 1'b0;
    end else if (ack_end && rd) begin
      tx_on <= 1'b1;
      if (st == ST_RCNT) begin
        tx <= bcnt;
      end else begin
        tx <= send_ok ? rd_byte : IDLE_BYTE;
      end
    end else if (scl_fall && tx_on && bitn != 4'h0) begin
      tx <= {tx[6:0], 1'b1};
    end
  end

  // control bytes; reserved bits are plain storage
  for (genvar g = 0; g < NUM_CTRL; g++) begin : g_ctrl
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
        regs[g] <= RST_CTRL[g];
      end else if (wr_en && idx == 7'(g)) begin
        regs[g] <= rx;
      end
    end
  end

  // block read byte count limit
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      bcnt <= RST_BCNT;
    end else if (wr_en && idx == REG_BCNT) begin
      bcnt <= rx;
    end
  end

  // enables registered, one clock behind the control bytes
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      REF_OUT0_ENABLE_O <= RST_CTRL[1][OE0_BIT];
      REF_OUT1_ENABLE_O <= RST_CTRL[1][OE1_BIT];
      REF_OUT2_ENABLE_O <= RST_CTRL[2][OE2_BIT];
      REF_OUT3_ENABLE_O <= RST_CTRL[2][OE3_BIT];
    end else begin
      REF_OUT0_ENABLE_O <= regs[1][OE0_BIT];
      REF_OUT1_ENABLE_O <= regs[1][OE1_BIT];
      REF_OUT2_ENABLE_O <= regs[2][OE2_BIT];
      REF_OUT3_ENABLE_O <= regs[2][OE3_BIT];
    end
  end

  // open drain: only ever pull low
  assign SDA_O = 1'b0;
  assign SDA_OE_O = acking | (tx_on & ~tx[7]);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  a_reset_defaults: assert property (
    $rose(RSTN_I) |-> regs[1] == RST_CTRL[1] && regs[2] == RST_CTRL[2] && bcnt == RST_BCNT)
    else $error("control bytes not at power-up values");
  a_own_addr_ack: assert property (
    byte_end && st == ST_ADDR && addr_hit |=> SDA_OE_O && acking)
    else $error("own address not acknowledged");
  a_foreign_quiet: assert property (
    byte_end && st == ST_ADDR && !addr_hit && !start_ev |=> !SDA_OE_O [*8])
    else $error("slave drove sda for a foreign address");
  a_cmd_form: assert property (
    byte_end && st == ST_CMD |=> st == ($past(rx[CMD_FORM_BIT]) ? ST_WDATA : ST_WCNT))
    else $error("command form bit decoded wrongly");
  a_cmd_index: assert property (
    byte_end && st == ST_CMD |=> idx == ($past(rx[CMD_FORM_BIT]) ? $past(rx[6:0]) : 7'h00))
    else $error("command index not taken");
  a_write_store: assert property (
    wr_en && idx == REG_OEA |=> regs[1] == $past(rx) ##1 REF_OUT0_ENABLE_O == regs[1][OE0_BIT])
    else $error("written byte not stored or not applied");
  a_index_ascend: assert property (
    wr_en || (ack_end && st == ST_RDATA) |=> idx == $past(idx) + 7'h01)
    else $error("index did not step by one");
  a_nack_ends: assert property (
    scl_rise && bitn == BYTE_BITS && rd && !acking && sda_s && !stop_ev && !start_ev |=> st == ST_IDLE)
    else $error("master nack did not end the read");
  a_stop_release: assert property (
    stop_ev |=> st == ST_IDLE && !SDA_OE_O)
    else $error("stop did not end the transfer");
  a_count_sent: assert property (
    ack_end && st == ST_RCNT |=> tx == bcnt && tx_on)
    else $error("block read count not the limit register");
  // enable pins, read limit, acks and stored bytes
  a_enable_map: assert property (
    1'b1 |=> REF_OUT0_ENABLE_O == $past(regs[1][OE0_BIT]) && REF_OUT1_ENABLE_O == $past(regs[1][OE1_BIT])
      && REF_OUT2_ENABLE_O == $past(regs[2][OE2_BIT]) && REF_OUT3_ENABLE_O == $past(regs[2][OE3_BIT]))
    else $error("output enable not taken from its control bit");
  a_limit_fill: assert property (
    ack_end && st == ST_RDATA && blk && rem == 8'h00 && !start_ev && !stop_ev |=> tx == IDLE_BYTE && tx_on)
    else $error("byte past the block read limit not all ones");
  a_data_ack: assert property (
    byte_end && (st == ST_CMD || st == ST_WCNT || st == ST_WDATA) && !start_ev && !stop_ev |=> acking)
    else $error("written byte not acknowledged");
  a_read_noack: assert property (
    byte_end && rd |=> !acking)
    else $error("slave acknowledged its own read byte");
  a_reserved_store: assert property (
    wr_en && idx == REG_CTRL0 |=> regs[0] == $past(rx))
    else $error("reserved control byte not stored");
  a_stop_keeps: assert property (
    stop_ev |=> regs[0] == $past(regs[0]) && regs[1] == $past(regs[1]) && regs[2] == $past(regs[2]))
    else $error("stop disturbed a completed byte");

  c_block_write: cover property (byte_end && st == ST_WDATA && blk ##[1:1000] stop_ev);
  c_byte_write: cover property (wr_en && !blk ##[1:1000] stop_ev);
  c_block_read: cover property (ack_end && st == ST_RCNT);
  c_byte_read: cover property (ack_end && st == ST_RDATA && !blk);
  c_block_limit: cover property (ack_end && st == ST_RDATA && blk && rem == 8'h00);
endmodule
`default_nettype wire

// File: smb_mst_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus controller model; pulls sda low through oe_o, wire has a pull-up
module smb_mst_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic oe_o
);
  // clock stands high outside frames, data released
  initial begin
    scl_o = 1'b1;
    oe_o = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // data moves mid low phase, sampled late in the high phase
  task automatic bx(input logic b, output logic q);
    scl_o = 1'b0;
    tk(5);
    oe_o = ~b;
    tk(5);
    scl_o = 1'b1;
    tk(10);
    q = sda_i;
  endtask
  // eight bits msb first, then the ninth slot
  task automatic by(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
    bx(a, k);
  endtask
  // start, or repeated start from a low clock
  task automatic st(input logic rep);
    if (rep) begin
      scl_o = 1'b0;
      tk(5);
      oe_o = 1'b0;
      tk(5);
      scl_o = 1'b1;
      tk(10);
    end
    oe_o = 1'b1;
    tk(10);
  endtask
  task automatic sp();
    scl_o = 1'b0;
    tk(5);
    oe_o = 1'b1;
    tk(5);
    scl_o = 1'b1;
    tk(10);
    oe_o = 1'b0;
    tk(10);
  endtask
  // write frame, stop may come after any whole byte; ok drops on any missing ack
  task automatic wr(input logic [7:0] b[$], output logic ok);
    logic [7:0] q;
    logic k;
    ok = 1'b1;
    st(1'b0);
    foreach (b[i]) begin
      by(b[i], 1'b1, q, k);
      ok &= (k === 1'b0);
    end
    sp();
  endtask
  // read frame: nack only the last byte
  task automatic rd(input logic [7:0] a, input logic [7:0] c, input int n, output logic [7:0] r[$]);
    logic [7:0] q;
    logic k;
    r = {};
    st(1'b0);
    by(a, 1'b1, q, k);
    by(c, 1'b1, q, k);
    st(1'b1);
    by(a | 8'h01, 1'b1, q, k);
    for (int i = 0; i < n; i++) begin
      by(8'hff, i == n - 1, q, k);
      r.push_back(q);
    end
    sp();
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import smb_pkg::*;
  logic clk, rst_n, scl, m_oe, sda_oe, sda_o, ok;
  logic [3:0] en;
  wire logic sda;
  logic [7:0] mdl [0:7];
  logic [7:0] r [$];
  int n_fail = 0;
  int check_count = 0;
  // open drain wire: an enabled pin shows its data value, pulled up when nobody pulls
  assign sda = m_oe ? 1'b0 : (sda_oe ? sda_o : 1'b1);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  smb_cfg_slave u_dut (.CLK_I(clk), .RSTN_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .REF_OUT0_ENABLE_O(en[0]), .REF_OUT1_ENABLE_O(en[1]), .REF_OUT2_ENABLE_O(en[2]), .REF_OUT3_ENABLE_O(en[3]));
  smb_mst_model u_mst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .oe_o(m_oe));
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_en();
    chk("enables", {4'h0, mdl[2][OE3_BIT], mdl[2][OE2_BIT], mdl[1][OE1_BIT], mdl[1][OE0_BIT]}, {4'h0, en});
  endtask
  // single byte write; index 3 and above 4 are dropped
  task automatic wr_b(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] c;
    c = {1'b1, a};
    u_mst.wr({8'hd2, c, v}, ok);
    chk("ack", 8'h01, {7'h0, ok});
    if (a != 7'h3 && a < 7'h5) mdl[a] = v;
  endtask
  task automatic rd_b(input logic [6:0] a);
    u_mst.rd(8'hd2, {1'b1, a}, 1, r);
    chk("byte", mdl[a], r[0]);
  endtask
  // block read: count, then bytes up to the limit, ff past it
  task automatic blk_rd(input int n);
    u_mst.rd(8'hd2, 8'h00, n, r);
    chk("count", mdl[4], r[0]);
    for (int i = 1; i < n; i++) chk("block", (i - 1 < mdl[4]) ? mdl[i - 1] : IDLE_BYTE, r[i]);
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    mdl = '{8'h00, 8'h05, 8'hc0, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
    void'($urandom(97));
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    chk_en();
    blk_rd(8);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      wr_b(7'(i), 8'($urandom));
      chk_en();
      rd_b(7'(i));
    end
    $display("test byte access done");
    mdl[0] = 8'($urandom);
    mdl[1] = 8'($urandom);
    u_mst.wr({8'hd2, 8'h00, 8'h03, mdl[0], mdl[1]}, ok);
    chk("block ack", 8'h01, {7'h0, ok});
    chk_en();
    wr_b(7'h4, 8'h02);
    blk_rd(5);
    $display("test block access done");
    u_mst.wr({8'ha4, 8'h81, 8'h00}, ok);
    chk("foreign ack", 8'h00, {7'h0, ok});
    rd_b(7'h1);
    chk_en();
    $display("test foreign address done");
    // a reset in mid-run must bring every byte back to its power-up value
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    mdl = '{8'h00, 8'h05, 8'hc0, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
    repeat (8) @(posedge clk);
    chk_en();
    blk_rd(8);
    $display("test mid-run reset done");
    stop_test();
  end
  // watchdog, well beyond the expected run
  initial begin
    #300us;
    n_fail++;
    $display("BAD watchdog expected done seen hang");
    stop_test();
  end
endmodule
`default_nettype wire
